/* File: rsc_reset_source_control.sv */
`timescale 1ns/1ps
// Summary of operation
// [RQ1] rtc unit may request reset on oscillator failure or alarm match
// [RQ2] oscillator fail: rtc detector enabled and rtc clock below about 20 kHz
// [RQ3] alarm event: alarm enabled and rtc counter equals alarm compare value
// [RQ4] bit 7 written 1 enables rtc reset source, 0 disables it
// [RQ5] rtc reset requests stay effective in suspend and sleep
// [RQ6] rtc-caused reset never drives the external reset pin
// [RQ7] writing 1 to bit 4 forces reset; bit 4 then reads 1
// [RQ8] bit 7 reads 1 when rtc alarm or oscillator fail caused last reset
// [RQ9] bit 6 read-only flash error flag; writes ignored
// [RQ10] bit 5 enables comparator source; reads 1 if comparator caused reset
// [RQ11] bit 3 read-only watchdog overflow flag
// [RQ12] bit 2 enables system missing-clock detector; reads 1 if it caused reset
// [RQ13] bit 1 enables supply monitor; reads 1 after power-on or monitor reset
// [RQ14] bit 0 read-only external pin reset flag
// [RQ15] with bit 1 set, other bits are undefined to software
// [RQ16] software enables supply monitor only once stable, else reset may follow
// [RQ17] read-modify-write changes single enables without side effects
// [RQ18] register sits at address 0xef, page 0x0
// [RQ19] bit 2 cleared stops detector; clock stuck over 100 us resets device
// [RQ20] each reset sets only the flag of its own source
module rsc_reset_source_control #(
	parameter int unsigned RTC_CNT_W  = 32,
	parameter int unsigned HOLD       = rsc_pkg::RSC_HOLD_CYCLES,
	parameter int unsigned MCD_LIMIT  = rsc_pkg::RSC_MCD_CYCLES,
	parameter int unsigned RTC_LIMIT  = rsc_pkg::RSC_RTC_HALF_CYCLES
) (
	// clock and power-on reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// special-function-register port of the core
	input  wire rsc_pkg::rsc_sfr_req_t  sfr_req,
	output logic [7:0]                  sfr_rdata,
	// same-clock reset requests and mode
	input  wire logic                   flash_err,
	input  wire logic                   wdt_ovf,
	input  wire logic                   low_power,
	input  wire logic                   cmp_wake_en,
	// asynchronous pins and analog levels
	input  wire logic                   pin_rst_n,
	input  wire logic                   vdd_low,
	input  wire logic                   cmp_out,
	input  wire logic                   rtc_clk,
	input  wire logic                   sys_clk_mon,
	// real-time-clock unit
	input  wire logic                   rtc_mcd_en,
	input  wire logic                   rtc_alarm_en,
	input  wire logic [RTC_CNT_W-1:0]   rtc_count,
	input  wire logic [RTC_CNT_W-1:0]   alarm_compare_registers,
	// system reset to the core and peripherals
	output logic                        sys_rst_n,
	output rsc_pkg::rsc_src_t           cause
);

	localparam int unsigned HC_W = $clog2(HOLD + 1);
	localparam logic [HC_W-1:0] HOLD_LAST = HC_W'(HOLD - 1);

	// ==========================================================
	// state
	rsc_pkg::rsc_state_t state_ff, nxt_state;
	logic [HC_W-1:0]     hold_ff, nxt_hold;
	rsc_pkg::rsc_src_t   cause_ff, nxt_cause;
	logic                sys_rst_n_ff, nxt_sys_rst_n;
	logic                en_rtc_ff, en_cmp_ff, en_mcd_ff, en_vmon_ff;
	logic                nxt_en_rtc, nxt_en_cmp, nxt_en_mcd, nxt_en_vmon;
	logic [7:0]          rdata_ff, nxt_rdata;

	// ==========================================================
	// synchronised pins
	// the filter costs four cycles; a pin pulse shorter than two cycles is lost
	logic [4:0] sync_q;
	logic       s_pin_n, s_vdd_low, s_cmp, s_rtc_clk, s_sysclk;

	rsc_sync3 #(
		.WIDTH   (5),
		.RST_VAL (rsc_pkg::RSC_SYNC_RST)
	) u_sync (
		.clk  (clk),
		.nrst (nrst),
		.din  ({sys_clk_mon, rtc_clk, cmp_out, vdd_low, pin_rst_n}),
		.dout (sync_q)
	);

	assign s_pin_n   = sync_q[0];
	assign s_vdd_low = sync_q[1];
	assign s_cmp     = sync_q[2];
	assign s_rtc_clk = sync_q[3];
	assign s_sysclk  = sync_q[4];

	// ==========================================================
	// clock-loss detectors
	logic mcd_fault, rtc_osc_fail, mcd_active, in_run;

	assign in_run = (state_ff == rsc_pkg::RSC_RUN);
	// [RQ19] detector gating by enable
	// suspended in low power; enable bit is untouched so it returns on wake
	// both detectors are held cleared in the hold, so each run starts a fresh count
	assign mcd_active = en_mcd_ff && !low_power && in_run;

	// [RQ19] system clock stuck timeout
	rsc_stuck_det #(
		.LIMIT (MCD_LIMIT)
	) u_sys_mcd (
		.clk   (clk),
		.nrst  (nrst),
		.en    (mcd_active),
		.level (s_sysclk),
		.stuck (mcd_fault)
	);

	// [RQ2] rtc clock too slow
	// a half period over the limit means below the minimum frequency
	rsc_stuck_det #(
		.LIMIT (RTC_LIMIT)
	) u_rtc_mcd (
		.clk   (clk),
		.nrst  (nrst),
		.en    (rtc_mcd_en && in_run),
		.level (s_rtc_clk),
		.stuck (rtc_osc_fail)
	);

	// ==========================================================
	// register access decode
	logic sfr_hit, wr_hit, rd_hit, sw_force;

	// [RQ18] page and address match
	always_comb begin
		sfr_hit = 1'b0;
		if (sfr_req.page == rsc_pkg::RSC_SFR_PAGE && sfr_req.addr == rsc_pkg::RSC_SFR_ADDR) begin
			sfr_hit = in_run;
		end
	end

	assign wr_hit = sfr_hit && sfr_req.wr;
	assign rd_hit = sfr_hit && sfr_req.rd;
	// [RQ17] no force on write-back
	// a read-modify-write would write back a set software flag; keep it quiet
	assign sw_force = wr_hit && !sfr_req.rmw && sfr_req.wdata[rsc_pkg::RSC_BIT_SW];

	// ==========================================================
	// source requests
	logic              rtc_alarm_hit;
	rsc_pkg::rsc_src_t trig, pick;

	// [RQ3] alarm compare
	// a match lasting several cycles still yields one reset per hold
	assign rtc_alarm_hit = rtc_alarm_en && (rtc_count == alarm_compare_registers);

	always_comb begin
		trig       = '0;
		trig.pin   = !s_pin_n;
		// [RQ16] monitor enable on low supply
		// setting the enable while the supply is still low trips a reset
		trig.vmon  = en_vmon_ff && s_vdd_low;
		trig.missing_clock_detector   = mcd_fault;
		// watchdog is stopped in low power
		trig.wdt   = wdt_ovf && !low_power;
		// [RQ7] software force
		trig.sw    = sw_force;
		trig.flash = flash_err;
		// [RQ10] comparator source gate
		// comparator output low trips; in low power only if also a wake source
		trig.cmp   = en_cmp_ff && !s_cmp && (!low_power || cmp_wake_en);
		// [RQ1] rtc request sources
		// [RQ5] no low power gating
		trig.rtc   = en_rtc_ff && (rtc_alarm_hit || rtc_osc_fail);
	end

	// [RQ20] single cause flag
	// fixed priority keeps exactly one flag when sources coincide
	// a losing source that is still active retriggers once the hold ends
	always_comb begin
		pick = '0;
		if (trig.pin) begin
			pick.pin = 1'b1;
		end else if (trig.vmon) begin
			pick.vmon = 1'b1;
		end else if (trig.missing_clock_detector) begin
			pick.missing_clock_detector = 1'b1;
		end else if (trig.wdt) begin
			pick.wdt = 1'b1;
		end else if (trig.sw) begin
			pick.sw = 1'b1;
		end else if (trig.flash) begin
			pick.flash = 1'b1;
		end else if (trig.cmp) begin
			pick.cmp = 1'b1;
		end else if (trig.rtc) begin
			pick.rtc = 1'b1;
		end
	end

	// ==========================================================
	// reset sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_hold  = hold_ff;
		nxt_cause = cause_ff;
		case (state_ff)
			rsc_pkg::RSC_RUN: begin
				if (|trig) begin
					nxt_state = rsc_pkg::RSC_HOLD;
					nxt_hold  = HOLD_LAST;
					nxt_cause = pick;
				end
			end
			rsc_pkg::RSC_HOLD: begin
				// pin and supply keep the core in reset for as long as they last
				// the counter runs first, so every reset lasts at least the full hold
				if (hold_ff != '0) begin
					nxt_hold = hold_ff - 1'b1;
				end else if (!trig.pin && !trig.vmon) begin
					nxt_state = rsc_pkg::RSC_RUN;
				end
			end
			default: begin
				nxt_state = rsc_pkg::RSC_HOLD;
				nxt_hold  = HOLD_LAST;
			end
		endcase
		// [RQ6] internal reset only
		// the reset pin is an input here; no source ever drives it
		nxt_sys_rst_n = (nxt_state == rsc_pkg::RSC_RUN);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff     <= rsc_pkg::RSC_HOLD;
			hold_ff      <= HOLD_LAST;
			// [RQ13] power-on flag
			cause_ff     <= rsc_pkg::RSC_CAUSE_POR;
			sys_rst_n_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			hold_ff      <= nxt_hold;
			cause_ff     <= nxt_cause;
			sys_rst_n_ff <= nxt_sys_rst_n;
		end
	end

	// ==========================================================
	// enable bits; they survive system resets, only power-on reloads them (supply monitor enable set, the others cleared)
	// writes in the hold are dropped by the decode, so a reset cannot race a write
	always_comb begin
		nxt_en_rtc  = en_rtc_ff;
		nxt_en_cmp  = en_cmp_ff;
		nxt_en_mcd  = en_mcd_ff;
		nxt_en_vmon = en_vmon_ff;
		if (wr_hit) begin
			// [RQ4] rtc enable write
			nxt_en_rtc  = sfr_req.wdata[rsc_pkg::RSC_BIT_RTC];
			// [RQ10] comparator enable write
			nxt_en_cmp  = sfr_req.wdata[rsc_pkg::RSC_BIT_CMP];
			// [RQ12] detector enable write
			nxt_en_mcd  = sfr_req.wdata[rsc_pkg::RSC_BIT_MCD];
			// [RQ13] supply monitor enable write
			nxt_en_vmon = sfr_req.wdata[rsc_pkg::RSC_BIT_VMON];
			// [RQ9] flash, watchdog and pin flags ignore writes
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en_rtc_ff  <= rsc_pkg::RSC_EN_RTC_RST;
			en_cmp_ff  <= rsc_pkg::RSC_EN_CMP_RST;
			en_mcd_ff  <= rsc_pkg::RSC_EN_MCD_RST;
			en_vmon_ff <= rsc_pkg::RSC_EN_VMON_RST;
		end else begin
			en_rtc_ff  <= nxt_en_rtc;
			en_cmp_ff  <= nxt_en_cmp;
			en_mcd_ff  <= nxt_en_mcd;
			en_vmon_ff <= nxt_en_vmon;
		end
	end

	// ==========================================================
	// read path: flags, not enables, are what software sees
	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_hit) begin
			// [RQ8] [RQ11] [RQ14] cause flags
			// flags read straight from the cause register
			nxt_rdata = cause_ff;
			// [RQ15] power-on masks the rest
			// the other bits are undefined then; zero is the defined choice
			// data is registered, so it stands for exactly one cycle after the read
			if (cause_ff.vmon) begin
				nxt_rdata = rsc_pkg::RSC_CAUSE_POR;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign sfr_rdata = rdata_ff;
	assign sys_rst_n = sys_rst_n_ff;
	assign cause     = cause_ff;

endmodule

/* File: rsc_pkg.sv */
package rsc_pkg;

	// ==========================================================
	// register location on the special-function-register bus
	localparam logic [7:0] RSC_SFR_PAGE = 8'h00;
	localparam logic [7:0] RSC_SFR_ADDR = 8'hef;

	// ==========================================================
	// bit positions inside reset_cause_and_enable
	localparam int unsigned RSC_BIT_RTC   = 7;
	localparam int unsigned RSC_BIT_FLASH = 6;
	localparam int unsigned RSC_BIT_CMP   = 5;
	localparam int unsigned RSC_BIT_SW    = 4;
	localparam int unsigned RSC_BIT_WDT   = 3;
	localparam int unsigned RSC_BIT_MCD   = 2;
	localparam int unsigned RSC_BIT_VMON  = 1;
	localparam int unsigned RSC_BIT_PIN   = 0;

	// ==========================================================
	// reset values (power-on)
	localparam logic [7:0] RSC_CAUSE_POR  = 8'h02;
	localparam logic       RSC_EN_RTC_RST  = 1'b0;
	localparam logic       RSC_EN_CMP_RST  = 1'b0;
	localparam logic       RSC_EN_MCD_RST  = 1'b0;
	localparam logic       RSC_EN_VMON_RST = 1'b1;
	localparam logic [4:0] RSC_SYNC_RST    = 5'h05;

	// ==========================================================
	// timing
	localparam longint unsigned RSC_CLK_HZ          = 64'd10_000_000;
	localparam longint unsigned RSC_MCD_TIMEOUT_US  = 64'd100;
	localparam longint unsigned RSC_RTC_MIN_FREQ_HZ = 64'd20_000;
	localparam int unsigned RSC_MCD_CYCLES =
		int'((RSC_MCD_TIMEOUT_US * RSC_CLK_HZ + 64'd999_999) / 64'd1_000_000);
	// a half period longer than this means the rtc clock is under the minimum
	localparam int unsigned RSC_RTC_HALF_CYCLES =
		int'((RSC_CLK_HZ + 2 * RSC_RTC_MIN_FREQ_HZ - 64'd1) / (2 * RSC_RTC_MIN_FREQ_HZ));
	localparam int unsigned RSC_HOLD_CYCLES = 16;

	// ==========================================================
	// one bit per reset source, laid out as the register bits
	typedef struct packed {
		logic rtc;
		logic flash;
		logic cmp;
		logic sw;
		logic wdt;
		logic missing_clock_detector;
		logic vmon;
		logic pin;
	} rsc_src_t;

	// core side register access
	typedef struct packed {
		logic [7:0] page;
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic       rmw;
		logic [7:0] wdata;
	} rsc_sfr_req_t;

	typedef enum logic [1:0] {
		RSC_RUN  = 2'b01,
		RSC_HOLD = 2'b10
	} rsc_state_t;

endpackage

/* File: rsc_sync3.sv */
`timescale 1ns/1ps
module rsc_sync3 #(
	parameter int unsigned WIDTH = 5,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// asynchronous in, filtered out
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
	logic [WIDTH-1:0] nxt_out;

	// ==========================================================
	// a bit only moves when stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
		end
	end

	// first stage feeds only the second, to let metastability settle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			out_ff <= RST_VAL;
		end else begin
			s1_ff  <= din;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign dout = out_ff;

endmodule

/* File: rsc_stuck_det.sv */
`timescale 1ns/1ps
module rsc_stuck_det #(
	parameter int unsigned LIMIT = 1000,
	parameter int unsigned CNT_W = $clog2(LIMIT + 1)
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// monitored level
	input  wire logic en,
	input  wire logic level,
	// level has not changed for LIMIT cycles
	output logic      stuck
);

	localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic             last_ff, stuck_ff, nxt_stuck;

	// ==========================================================
	// count cycles since the last edge; disabled means no count at all
	always_comb begin
		nxt_cnt = cnt_ff;
		if (!en || level != last_ff) begin
			nxt_cnt = '0;
		end else if (cnt_ff != LIM) begin
			nxt_cnt = cnt_ff + 1'b1;
		end
		nxt_stuck = en && (nxt_cnt == LIM);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff   <= '0;
			last_ff  <= 1'b0;
			stuck_ff <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			last_ff  <= level;
			stuck_ff <= nxt_stuck;
		end
	end

	assign stuck = stuck_ff;

endmodule

/* File: rsc_chk_asserts.sv */
`timescale 1ns/1ps
module rsc_chk_asserts #(
	parameter int unsigned RTC_CNT_W = 32
) (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  nrst,
	// register port
	input wire rsc_pkg::rsc_sfr_req_t sfr_req,
	input wire logic [7:0]            sfr_rdata,
	// sources
	input wire logic                  flash_err,
	input wire logic                  wdt_ovf,
	input wire logic                  low_power,
	input wire logic                  rtc_mcd_en,
	input wire logic                  rtc_alarm_en,
	input wire logic [RTC_CNT_W-1:0]  rtc_count,
	input wire logic [RTC_CNT_W-1:0]  alarm_compare_registers,
	// system reset out
	input wire logic                  sys_rst_n,
	input wire rsc_pkg::rsc_src_t     cause
);
	// ==========================================================
	// helpers: an access is only taken outside the reset hold
	logic hit;
	logic rtc_ev;
	logic wdt_ok;
	assign hit = sfr_req.page == 8'h00 && sfr_req.addr == 8'hef && sys_rst_n;
	assign rtc_ev = rtc_mcd_en || (rtc_alarm_en && rtc_count == alarm_compare_registers);
	assign wdt_ok = wdt_ovf && !low_power;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// software force
	sw_force_a: assert property (hit && sfr_req.wr && !sfr_req.rmw && sfr_req.wdata[4]
		|=> !sys_rst_n && cause == 8'h10) else $error("software write gave no reset");
	rd_idle_a: assert property (!(hit && sfr_req.rd) |=> sfr_rdata == 8'h00)
		else $error("read data outside a read");
	rd_por_a: assert property (hit && sfr_req.rd && cause.vmon |=> sfr_rdata == 8'h02)
		else $error("power-on read not clean");
	// flag read, against the flags seen when the read was taken
	rd_flag_a: assert property (hit && sfr_req.rd && !cause.vmon |=> sfr_rdata == $past(cause))
		else $error("read does not show cause");
	one_flag_a: assert property ($onehot(cause)) else $error("cause not one-hot");
	cause_hold_a: assert property (!$fell(sys_rst_n) |-> $stable(cause))
		else $error("cause moved without reset");
	hold_len_a: assert property ($fell(sys_rst_n) |-> !sys_rst_n [*8])
		else $error("reset hold too short");
	wdt_src_a: assert property ($fell(sys_rst_n) && cause.wdt |-> $past(wdt_ok))
		else $error("watchdog flag without request");
	flash_src_a: assert property ($fell(sys_rst_n) && cause.flash |-> $past(flash_err))
		else $error("flash flag without request");
	rtc_src_a: assert property ($fell(sys_rst_n) && cause.rtc |-> $past(rtc_ev))
		else $error("rtc flag without event");
	rmw_quiet_a: assert property (hit && sfr_req.wr && sfr_req.rmw |=> $stable(cause) || !cause.sw)
		else $error("write-back forced a reset");
	// ==========================================================
	// main scenarios
	rtc_c: cover property ($fell(sys_rst_n) && cause.rtc);
	mcd_c: cover property ($fell(sys_rst_n) && cause.missing_clock_detector);
	sw_c: cover property ($fell(sys_rst_n) && cause.sw);
	rd_c: cover property (hit && sfr_req.rd && !cause.vmon);
endmodule

/* File: rsc_src_model.sv */
`timescale 1ns/1ps
module rsc_src_model (
	// clock and controls
	input wire logic clk,
	input wire logic rtc_run,
	input wire logic mcd_run,
	// monitored clocks
	output logic     rtc_clk,
	output logic     sys_clk_mon
);
	// ==========================================================
	// rtc oscillator, stopping models a dead crystal
	logic [1:0] div_ff = 2'h0;
	initial rtc_clk = 1'b0;
	initial sys_clk_mon = 1'b0;
	always @(posedge clk) begin
		if (rtc_run) begin
			div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
			if (div_ff == 2'h2) rtc_clk <= !rtc_clk; // half period 3 cycles, well below the limit
		end
	end
	// system clock activity, stuck when stopped
	// the level holds four cycles; a toggle every cycle never passes the three-stage filter
	logic [1:0] act_ff = 2'h0;
	always @(posedge clk) begin
		if (mcd_run) begin
			act_ff <= act_ff + 2'h1;
			if (act_ff == 2'h3) sys_clk_mon <= !sys_clk_mon;
		end
	end
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	// ==========================================================
	// signals
	logic                  clk = 1'b0;
	logic                  nrst = 1'b0;
	rsc_pkg::rsc_sfr_req_t req = '0;
	logic [7:0]            rdata;
	logic                  ferr = 1'b0, wdt = 1'b0, lp = 1'b0, cwk = 1'b0;
	logic                  pin_n = 1'b1, vlow = 1'b0, cmp = 1'b1;
	logic                  rclk, smon, rrun = 1'b1, mrun = 1'b1;
	logic                  rmcd = 1'b0, ralm = 1'b0;
	logic [31:0]           cnt = '0, alm = 32'h1;
	logic                  sys_rst_n;
	rsc_pkg::rsc_src_t     cause;
	int                    errors = 0, total_checks = 0, cyc = 0;
	rsc_reset_source_control #(.MCD_LIMIT(20), .RTC_LIMIT(8)) u_rsc_reset_source_control (.clk(clk), .nrst(nrst),
		.sfr_req(req), .sfr_rdata(rdata), .flash_err(ferr), .wdt_ovf(wdt), .low_power(lp), .cmp_wake_en(cwk),
		.pin_rst_n(pin_n), .vdd_low(vlow), .cmp_out(cmp), .rtc_clk(rclk), .sys_clk_mon(smon),
		.rtc_mcd_en(rmcd), .rtc_alarm_en(ralm), .rtc_count(cnt), .alarm_compare_registers(alm),
		.sys_rst_n(sys_rst_n), .cause(cause));
	rsc_src_model u_rsc_src_model (.clk(clk), .rtc_run(rrun), .mcd_run(mrun), .rtc_clk(rclk), .sys_clk_mon(smon));
	// ==========================================================
	// clock and hang guard
	initial forever #50 clk = !clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	// ==========================================================
	// bus and check tasks, inputs move 1 ns after the edge
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// a trailing edge keeps the next request from reassigning req in the same step
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic m);
		req = '{8'h00, a, 1'b1, 1'b0, m, d};
		tick();
		req.wr = 1'b0;
		tick();
	endtask
	task automatic rd(input logic [7:0] e);
		req = '{8'h00, 8'hef, 1'b0, 1'b1, 1'b0, 8'h00};
		tick();
		req.rd = 1'b0;
		chk(rdata, e);
		tick();
	endtask
	// expected read after a reset from source bit b
	function automatic logic [7:0] flag(input int b);
		return 8'h01 << b;
	endfunction
	task automatic wait_rst(input logic [7:0] e);
		int i;
		for (i = 0; i < 60 && sys_rst_n !== 1'b0; i++) tick();
		chk({7'h0, sys_rst_n}, 8'h00);
		for (i = 0; i < 200 && sys_rst_n !== 1'b1; i++) tick();
		chk({7'h0, sys_rst_n}, 8'h01);
		chk(cause, e);
		rd(e);
	endtask
	task automatic no_rst();
		tick(30);
		chk({7'h0, sys_rst_n}, 8'h01);
	endtask
	task automatic report_and_stop();
		if (errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(23278));
		tick(6);
		nrst = 1'b1;
		wait_rst(flag(1));
		wr(8'hef, 8'($urandom) & 8'hef, 1'b0);
		rd(flag(1));
		wr(8'hee, 8'h10, 1'b0);
		no_rst();
		wr(8'hef, 8'h10, 1'b1);
		no_rst();
		wr(8'hef, 8'h10, 1'b0);
		wait_rst(flag(4));
		ferr = 1'b1;
		tick();
		ferr = 1'b0;
		wait_rst(flag(6));
		lp = 1'b1;
		wdt = 1'b1;
		no_rst();
		lp = 1'b0;
		tick();
		wdt = 1'b0;
		wait_rst(flag(3));
		pin_n = 1'b0;
		tick(5);
		pin_n = 1'b1;
		wait_rst(flag(0));
		wr(8'hef, 8'h00, 1'b0);
		{cmp, mrun, vlow} = 3'b001;
		no_rst();
		{cmp, mrun, vlow} = 3'b110;
		// monitor enabled only once
		// the filtered supply level has settled before the enable is written
		tick(6);
		wr(8'hef, 8'h02, 1'b0);
		vlow = 1'b1;
		tick(5);
		vlow = 1'b0;
		wait_rst(flag(1));
		// comparator in low power trips only while it is also a wake source
		wr(8'hef, 8'h20, 1'b0);
		{lp, cmp} = 2'b10;
		no_rst();
		cwk = 1'b1;
		tick(2);
		{lp, cwk, cmp} = 3'b001;
		wait_rst(flag(5));
		wr(8'hef, 8'h04, 1'b0);
		mrun = 1'b0;
		tick(15);
		chk({7'h0, sys_rst_n}, 8'h01);
		tick(15);
		mrun = 1'b1;
		wait_rst(flag(2));
		wr(8'hef, 8'h80, 1'b0);
		{lp, ralm, cnt} = {2'b11, 32'($urandom)};
		alm = cnt;
		tick();
		cnt = cnt + 32'h1;
		wait_rst(flag(7));
		lp = 1'b0;
		{rmcd, rrun} = 2'b10;
		tick(20);
		{rmcd, rrun} = 2'b01;
		wait_rst(flag(7));
		wr(8'hef, 8'h00, 1'b0);
		alm = cnt;
		tick();
		cnt = cnt + 32'h1;
		no_rst();
		report_and_stop();
	end
endmodule
bind rsc_reset_source_control rsc_chk_asserts #(.RTC_CNT_W(RTC_CNT_W)) u_rsc_chk_asserts (.clk(clk), .nrst(nrst),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .flash_err(flash_err), .wdt_ovf(wdt_ovf), .low_power(low_power),
	.rtc_mcd_en(rtc_mcd_en), .rtc_alarm_en(rtc_alarm_en), .rtc_count(rtc_count),
	.alarm_compare_registers(alarm_compare_registers), .sys_rst_n(sys_rst_n), .cause(cause));
